/* File: inc/svt_pkg.sv */
// types shared by the sequence voltage trip timer and its stage module
`include "svt_regs.svh"
package svt_pkg;
   // per-stage settings, one group of fields per stage
   typedef struct packed {
      logic                   inverse;       // 0 definite time, 1 inverse time
      logic                   under;         // 0 over supervision, 1 under
      logic [`SVT_OP_W-1:0]   dt_ticks;      // definite delay in 5 ms ticks
      logic [`SVT_REL_W-1:0]  rel_ticks;     // release delay in 5 ms ticks
      logic [`SVT_K_W-1:0]    k_dial;        // time dial in 10 ms units
      logic [`SVT_EXP_W-1:0]  exponent;      // exponent in 0.01 units
      logic                   dly_rel_en;    // delayed pick-up release
      logic                   rst_after_rel; // timer clears after release delay
      logic                   cont_en;       // timer continues during release
   } svt_cfg_t;

   // stage outputs
   typedef struct packed {
      logic start;
      logic trip;
      logic blocked;
   } svt_status_t;

   typedef enum logic [1:0] {SVT_EV_START, SVT_EV_TRIP, SVT_EV_BLOCK} svt_kind_t;

   // one time-stamped event message
   typedef struct packed {
      logic [1:0]            stage;
      svt_kind_t             kind;
      logic                  rising;
      logic [`SVT_TS_W-1:0]  stamp;
   } svt_event_t;

   // one operation record
   typedef struct packed {
      svt_kind_t               kind;
      logic [`SVT_TS_W-1:0]    stamp;
      logic [`SVT_VOLT_W-1:0]  v_pre20;
      logic [`SVT_VOLT_W-1:0]  v_fault;
      logic [`SVT_VOLT_W-1:0]  v_pre200;
      logic [`SVT_OP_W-1:0]    remaining;
      logic [2:0]              group;
   } svt_record_t;
endpackage

/* File: inc/svt_regs.svh */
// timing counts, field widths and setting defaults for the sequence voltage trip timer
`ifndef SVT_REGS_SVH
`define SVT_REGS_SVH

`define SVT_CLK_PERIOD_NS   25
`define SVT_TICK_NS         5000000
`define SVT_TICK_CYCLES     (`SVT_TICK_NS / `SVT_CLK_PERIOD_NS)
`define SVT_STAGES          4
`define SVT_LOG_DEPTH       12
`define SVT_PRE20_TICKS     4
`define SVT_PRE200_TICKS    40
`define SVT_OP_W            19
`define SVT_REL_W           15
`define SVT_K_W             13
`define SVT_EXP_W           12
`define SVT_ACC_W           24
`define SVT_RATIO_W         16
`define SVT_RATIO_ONE       16'h0100
`define SVT_K_SHIFT         9
`define SVT_VOLT_W          16
`define SVT_TS_W            32
`define SVT_CNT_W           16
`define SVT_DEF_DT_TICKS    19'h00008
`define SVT_DEF_REL_TICKS   15'h000C
`define SVT_DEF_K_DIAL      13'h0005
`define SVT_DEF_EXPONENT    12'h064

`endif

/* File: rtl/svt_stage.sv */
// one protection stage: start, trip and blocked timing on the processing tick
`timescale 1ns/1ps
`include "svt_regs.svh"
module svt_stage (
   // clock and reset
   input  wire logic                      clk,
   input  wire logic                      rst,
   input  wire logic                      tick,
   // settings and inputs
   input  wire svt_pkg::svt_cfg_t         cfg,
   input  wire logic                      pick,
   input  wire logic                      block,
   input  wire logic [`SVT_RATIO_W-1:0]   ratio_pow,
   // outputs
   output svt_pkg::svt_status_t           status,
   output logic [`SVT_OP_W-1:0]           remaining
);
   import svt_pkg::*;

   logic [`SVT_OP_W-1:0]   op_cnt;    // definite-time elapsed ticks
   logic [`SVT_ACC_W-1:0]  acc;       // inverse-time integral
   logic [`SVT_REL_W-1:0]  rel_cnt;   // release elapsed ticks
   logic                   running;   // pick-up and not blocked
   logic                   pending;   // something still to release
   logic [`SVT_OP_W-1:0]   next_op;
   logic [`SVT_ACC_W-1:0]  next_acc;
   logic [`SVT_RATIO_W-1:0] inc;
   logic                   trip_due;
   logic                   rel_end;

   // inverse-time rate: integrate |p-1| each tick, trip at 2k (k in 10 ms units)
   always_comb begin
      running = pick & ~block;
      pending = status.start | (op_cnt != '0) | (acc != '0);
      if (cfg.under) begin
         inc = (ratio_pow < `SVT_RATIO_ONE) ? `SVT_RATIO_ONE - ratio_pow : '0;
      end else begin
         inc = (ratio_pow > `SVT_RATIO_ONE) ? ratio_pow - `SVT_RATIO_ONE : '0;
      end
      // newly started stage counts from zero, so dt of zero trips at once
      next_op  = status.start ? op_cnt + 1'b1 : op_cnt;
      next_acc = acc + {8'h00, inc};
      if (cfg.inverse) begin
         trip_due = next_acc >= {2'b00, cfg.k_dial, 9'h000};
      end else begin
         trip_due = next_op >= cfg.dt_ticks;
      end
      rel_end = ({1'b0, rel_cnt} + 1'b1) >= {1'b0, cfg.rel_ticks};
   end

   // start, trip and blocked outputs, updated only on the tick
   always_ff @(posedge clk) begin
      if (rst) begin
         status <= '0;
      end else if (tick) begin
         status.blocked <= pick & block;
         if (running) begin
            status.start <= 1'b1;
            status.trip  <= trip_due;
         end else begin
            status.trip <= 1'b0;
            // a block at pick-up drops start at once, then releases normally
            if (pick & block) begin
               status.start <= 1'b0;
            end else if (!cfg.dly_rel_en || rel_end) begin
               status.start <= 1'b0;
            end
         end
      end
   end

   // operating timers: count while running, then clear, hold or continue
   always_ff @(posedge clk) begin
      if (rst) begin
         op_cnt <= '0;
         acc    <= '0;
      end else if (tick) begin
         if (running) begin
            if (cfg.inverse) begin
               acc <= next_acc;
            end else begin
               op_cnt <= next_op;
            end
         end else if (pending) begin
            if (rel_end || !cfg.rst_after_rel) begin
               op_cnt <= '0;
               acc    <= '0;
            end else if (cfg.cont_en) begin
               // keeps counting but cannot trip until pick-up returns
               op_cnt <= op_cnt + 1'b1;
               if (cfg.inverse) begin
                  acc <= next_acc;
               end
            end
         end
      end
   end

   // release delay counter
   always_ff @(posedge clk) begin
      if (rst) begin
         rel_cnt <= '0;
      end else if (tick) begin
         if (running || !pending || rel_end) begin
            rel_cnt <= '0;
         end else begin
            rel_cnt <= rel_cnt + 1'b1;
         end
      end
   end

   // remaining trip time, definite mode only; inverse mode shows zero
   always_ff @(posedge clk) begin
      if (rst) begin
         remaining <= '0;
      end else begin
         remaining <= (!cfg.inverse && status.start && !status.trip
                       && cfg.dt_ticks > op_cnt) ? cfg.dt_ticks - op_cnt : '0;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_instant_trip: assert property (tick && running && !cfg.inverse && cfg.dt_ticks == '0
      |=> status.trip && status.start) else $error("instant trip missing");
   a_trip_needs_start: assert property (status.trip |-> status.start)
      else $error("trip without start");
   a_no_trip_release: assert property (tick && !running |=> !status.trip)
      else $error("trip during release");
   a_block_no_start: assert property (tick && pick && block |=> status.blocked && !status.start)
      else $error("block did not stop start");
   a_fast_release: assert property (tick && !pick && !cfg.dly_rel_en |=> !status.start)
      else $error("start held without delayed release");
   a_timer_clear: assert property (tick && !running && !cfg.rst_after_rel |=> op_cnt == '0)
      else $error("timer not cleared at pick-up loss");
   a_start_on_pick: assert property (tick && running |=> status.start)
      else $error("start missing on pick-up");
   a_tick_only: assert property (!tick && !rst |=> $stable(status))
      else $error("status moved off tick");
   c_dt_trip: cover property (tick && running && !cfg.inverse ##1 $rose(status.trip));
   c_release: cover property (status.start && !pick && cfg.dly_rel_en);
endmodule

/* File: rtl/svt_timer.sv */
// four-stage sequence voltage trip timer with events, counters and record logs
//
// Overview of operation
// - instant mode trips together with start
// - definite mode trips after set delay
// - definite delay 0 to 1800 s, 5 ms
// - inverse delay k over ratio power difference
// - time dial 0.01 to 60 s
// - exponent 0.01 to 25, default 1.00
// - selector picks definite or inverse counting
// - release delay 0 to 150 s, 5 ms
// - delayed release holds start through release delay
// - timer clears after release or at loss
// - optional timer continuation during release delay
// - no trip while continuing without pick-up
// - time-stamped edge events with edge selection
// - resettable counters of start, trip, blocked
// - four independent stages with own events
// - twelve newest records kept per stage
// - record holds name, time, voltages, remaining, group
// - unblocked pick-up asserts start and timing
// - blocked pick-up asserts blocked, no timing
`timescale 1ns/1ps
`include "svt_regs.svh"
module svt_timer #(
   parameter int TICK_CYCLES = `SVT_TICK_CYCLES   // clock cycles per processing tick
) (
   // clock and reset
   input  wire logic                                   clk,
   input  wire logic                                   rst,
   // per-stage settings and pick-up/blocking inputs
   input  wire svt_pkg::svt_cfg_t [`SVT_STAGES-1:0]    cfg,
   input  wire logic [`SVT_STAGES-1:0]                 pick,
   input  wire logic [`SVT_STAGES-1:0]                 block,
   input  wire logic [`SVT_STAGES-1:0][`SVT_RATIO_W-1:0] ratio_pow,
   output logic [`SVT_STAGES-1:0][`SVT_EXP_W-1:0]      pow_exponent,
   // measurement and context
   input  wire logic [`SVT_VOLT_W-1:0]                 measured_voltage,
   input  wire logic [2:0]                             setting_group,
   // event edge selection: bit 0 rising, bit 1 falling, per kind
   input  wire logic [2:0][1:0]                        event_sel,
   input  wire logic                                   count_clear,
   // stage outputs
   output svt_pkg::svt_status_t [`SVT_STAGES-1:0]      status,
   // event stream
   output logic                                        event_valid,
   output svt_pkg::svt_event_t                         event_msg,
   // event counters
   output logic [`SVT_STAGES-1:0][2:0][`SVT_CNT_W-1:0] event_count,
   // record log read port, age 0 is the newest
   input  wire logic [1:0]                             log_stage,
   input  wire logic [3:0]                             log_age,
   output logic                                        log_valid,
   output svt_pkg::svt_record_t                        log_data
);
   import svt_pkg::*;

   localparam int NEV = `SVT_STAGES * 6;   // stage x kind x edge
   localparam int HD  = `SVT_PRE200_TICKS;

   logic [$clog2(TICK_CYCLES)-1:0]           div;         // tick divider
   logic                                     tick;        // one cycle every 5 ms
   logic [`SVT_TS_W-1:0]                     stamp;       // time in ticks
   logic [`SVT_STAGES-1:0][`SVT_OP_W-1:0]    remaining;   // per-stage time to trip
   svt_status_t [`SVT_STAGES-1:0]            prev;        // status one cycle back
   logic [NEV-1:0]                           pend;        // events waiting for output
   logic [NEV-1:0]                           raise;       // new edges this cycle
   logic [NEV-1:0]                           take;        // one-hot event leaving
   logic [$clog2(NEV)-1:0]                   sel_idx;     // index of taken event
   logic                                     any;
   logic [1:0]                               ev_stage;
   logic [1:0]                               ev_kind;
   logic                                     ev_rise;
   logic [`SVT_VOLT_W-1:0]                   hist [HD];   // voltage history
   logic [$clog2(HD)-1:0]                    hptr;        // oldest history entry
   svt_record_t                              logm [`SVT_STAGES][`SVT_LOG_DEPTH];
   logic [`SVT_STAGES-1:0][3:0]              wptr;        // next log slot
   logic [`SVT_STAGES-1:0][3:0]              filled;      // records held
   logic [3:0]                               rd_idx;

   // processing tick and time stamp
   always_ff @(posedge clk) begin
      if (rst) begin
         div   <= '0;
         stamp <= '0;
      end else if (div == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1)) begin
         div   <= '0;
         stamp <= stamp + 1'b1;
      end else begin
         div <= div + 1'b1;
      end
   end
   assign tick = (div == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1));

   // four independent stages
   for (genvar s = 0; s < `SVT_STAGES; s++) begin : g_stage
      svt_stage u_stage (
         .clk       (clk),
         .rst       (rst),
         .tick      (tick),
         .cfg       (cfg[s]),
         .pick      (pick[s]),
         .block     (block[s]),
         .ratio_pow (ratio_pow[s]),
         .status    (status[s]),
         .remaining (remaining[s])
      );
      // exponent goes to the front end that forms the ratio power
      assign pow_exponent[s] = cfg[s].exponent;
      for (genvar k = 0; k < 3; k++) begin : g_kind
         // rising edges always queue, they feed counters and the log
         assign raise[s*6+k*2]   = status[s][2-k] & ~prev[s][2-k];
         assign raise[s*6+k*2+1] = ~status[s][2-k] & prev[s][2-k] & event_sel[k][1];
      end
   end

   // edge history
   always_ff @(posedge clk) begin
      if (rst) begin
         prev <= '0;
      end else begin
         prev <= status;
      end
   end

   // lowest pending event leaves first; edges drain long before the next tick
   always_comb begin
      any     = 1'b0;
      sel_idx = '0;
      for (int i = NEV - 1; i >= 0; i--) begin
         if (pend[i]) begin
            any     = 1'b1;
            sel_idx = ($clog2(NEV))'(i);
         end
      end
      take     = any ? (NEV)'(1) << sel_idx : '0;
      ev_stage = 2'(sel_idx / 6);
      ev_kind  = 2'((sel_idx % 6) / 2);
      ev_rise  = ~sel_idx[0];
   end

   // pending set wins over the clear of the same cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         pend <= '0;
      end else begin
         pend <= (pend & ~take) | raise;
      end
   end

   // event stream, filtered by the per-kind edge selection
   always_ff @(posedge clk) begin
      if (rst) begin
         event_valid <= 1'b0;
         event_msg   <= '0;
      end else begin
         event_valid <= any && event_sel[ev_kind][ev_rise ? 0 : 1];
         event_msg   <= '{stage: ev_stage, kind: svt_kind_t'(ev_kind),
                          rising: ev_rise, stamp: stamp};
      end
   end

   // cumulative counters; an event in the clear cycle counts as one
   always_ff @(posedge clk) begin
      if (rst) begin
         event_count <= '0;
      end else begin
         for (int s = 0; s < `SVT_STAGES; s++) begin
            for (int k = 0; k < 3; k++) begin
               if (any && ev_rise && ev_stage == 2'(s) && ev_kind == 2'(k)) begin
                  event_count[s][k] <= count_clear ? 16'h0001
                                                   : event_count[s][k] + 1'b1;
               end else if (count_clear) begin
                  event_count[s][k] <= '0;
               end
            end
         end
      end
   end

   // voltage history, one sample per tick, 40 deep for the 200 ms look-back
   always_ff @(posedge clk) begin
      if (rst) begin
         hptr <= '0;
      end else if (tick) begin
         hist[hptr] <= measured_voltage;
         hptr       <= (hptr == ($clog2(HD))'(HD - 1)) ? '0 : hptr + 1'b1;
      end
   end

   // record log, circular per stage, oldest overwritten first
   always_ff @(posedge clk) begin
      if (rst) begin
         wptr   <= '0;
         filled <= '0;
      end else if (any && ev_rise) begin
         logm[ev_stage][wptr[ev_stage]] <= '{
            kind:      svt_kind_t'(ev_kind),
            stamp:     stamp,
            v_pre20:   hist[(hptr + HD - `SVT_PRE20_TICKS) % HD],
            v_fault:   measured_voltage,
            v_pre200:  hist[hptr],
            remaining: remaining[ev_stage],
            group:     setting_group};
         wptr[ev_stage] <= (wptr[ev_stage] == 4'(`SVT_LOG_DEPTH - 1)) ? '0
                           : wptr[ev_stage] + 1'b1;
         if (filled[ev_stage] != 4'(`SVT_LOG_DEPTH)) begin
            filled[ev_stage] <= filled[ev_stage] + 1'b1;
         end
      end
   end

   // log read port, one cycle latency
   // five bits so the sum never wraps before the modulo on a late write pointer
   assign rd_idx = 4'((5'(wptr[log_stage]) + 5'(`SVT_LOG_DEPTH - 1) - 5'(log_age))
                      % 5'(`SVT_LOG_DEPTH));
   always_ff @(posedge clk) begin
      if (rst) begin
         log_valid <= 1'b0;
         log_data  <= '0;
      end else begin
         log_valid <= log_age < filled[log_stage];
         log_data  <= logm[log_stage][rd_idx];
      end
   end

   // block input is taken on the tick, so it only has to be present at the tick on which expiry falls

   a_tick_period: assert property (@(posedge clk) disable iff (rst)
      tick |=> !tick) else $error("tick wider than one cycle");
   a_start_event: assert property (@(posedge clk) disable iff (rst)
      $rose(status[0].start) |=> pend[0]) else $error("start edge not queued");
   a_count_clear: assert property (@(posedge clk) disable iff (rst)
      count_clear && !any |=> event_count == '0) else $error("counter not cleared");
   a_log_bound: assert property (@(posedge clk) disable iff (rst)
      filled[0] <= 4'(`SVT_LOG_DEPTH)) else $error("log overfilled");
   c_event_out: cover property (@(posedge clk) event_valid && event_msg.rising);
   c_log_wrap: cover property (@(posedge clk) filled[0] == 4'(`SVT_LOG_DEPTH) && any);
endmodule

/* File: tb/svt_front.sv */
// pick-up comparator and blocking matrix model for stage 0, with event tally
`timescale 1ns/1ps
module svt_front (
   // clock
   input  wire logic        clk,
   // bench commands
   input  wire logic [15:0] ratio,
   input  wire logic        under,
   input  wire logic        blk_req,
   // stage side
   output logic             pick,
   output logic             block,
   output logic [15:0]      ratio_pow,
   // event stream side
   input  wire logic        ev_valid,
   output int               ev_seen
);
   // exponent 1.00 is used, so the power is the ratio itself
   assign ratio_pow = ratio;
   // comparison against the 1.0 pick-up point, direction chosen by under
   assign pick = under ? (ratio < 16'h0100) : (ratio > 16'h0100);
   // block raised whole ticks ahead of any expiry
   assign block = blk_req;
   // tally of every event pulse taken from the stream
   initial ev_seen = 0;
   always @(posedge clk) if (ev_valid) ev_seen <= ev_seen + 1;
endmodule

/* File: tb/svt_timer_test.sv */
// self-checking bench for the four-stage trip timer
`timescale 1ns/1ps
`include "svt_regs.svh"
module svt_timer_test;
   import svt_pkg::*;
   logic clk = 0, rst = 1, under = 0, blk_req = 0, count_clear = 0;
   logic [15:0] ratio = 16'h0100;                 // stage 0 ratio, 1.0 is idle
   logic [15:0] volt = 16'h1234;                  // measured voltage seen by the log
   logic [3:1] pk = 0;                            // direct pick-ups of stages 1..3
   svt_cfg_t [3:0] cfg;                           // per-stage settings
   logic [2:0][1:0] event_sel = '0;               // edge selection per kind
   logic [1:0] log_stage = 0;                     // log read select
   logic [3:0] log_age = 0;                       // log read age
   logic f_pick, f_block, ev_valid;
   logic [15:0] f_pow;
   int ev_seen, mismatches = 0, tests_run = 0;
   svt_status_t [3:0] status;
   svt_event_t ev_msg;
   logic [3:0][2:0][15:0] ev_cnt;
   logic [3:0][11:0] pow_exp;
   logic log_valid;
   svt_record_t log_data;
   // a short tick of 8 cycles keeps every delay quick to reach
   always #12.5 clk = ~clk;
   svt_front front (.clk(clk), .ratio(ratio), .under(under), .blk_req(blk_req),
      .pick(f_pick), .block(f_block), .ratio_pow(f_pow), .ev_valid(ev_valid),
      .ev_seen(ev_seen));
   svt_timer #(.TICK_CYCLES(8)) uut (.clk(clk), .rst(rst), .cfg(cfg),
      .pick({pk, f_pick}), .block({3'h0, f_block}),
      .ratio_pow({{3{16'h0100}}, f_pow}), .pow_exponent(pow_exp),
      .measured_voltage(volt), .setting_group(3'h5), .event_sel(event_sel),
      .count_clear(count_clear), .status(status), .event_valid(ev_valid),
      .event_msg(ev_msg), .event_count(ev_cnt), .log_stage(log_stage),
      .log_age(log_age), .log_valid(log_valid), .log_data(log_data));
   task check(input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task final_report;
      $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
      if (mismatches == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // stage 0 settings in definite mode
   task set0(input int dt, input int rel, input logic dly, rar, cont);
      cfg[0] = '0;
      cfg[0].dt_ticks = dt[`SVT_OP_W-1:0];
      cfg[0].rel_ticks = rel[`SVT_REL_W-1:0];
      cfg[0].exponent = `SVT_DEF_EXPONENT;
      cfg[0].dly_rel_en = dly;
      cfg[0].rst_after_rel = rar;
      cfg[0].cont_en = cont;
   endtask
   // drop pick-up and let every release run out
   task quiet;
      ratio = 16'h0100;
      blk_req = 0;
      repeat (100) @(negedge clk);
   endtask
   // raise pick-up and wait for start; leaves us just after a tick
   task wait_start(input logic [15:0] r);
      ratio = r;
      for (int i = 0; i < 40 && status[0].start !== 1'b1; i++) @(negedge clk);
      check(status[0].start, 1);
   endtask
   task t_instant;
      set0(0, 2, 1, 1, 0);
      wait_start(16'h0200);
      check(status[0].trip, 1);
      quiet;
   endtask
   task t_definite;
      set0(3, 2, 1, 1, 0);
      wait_start(16'h0200);
      repeat (20) @(negedge clk);
      check(status[0].trip, 0);
      repeat (8) @(negedge clk);
      check(status[0].trip, 1);
      ratio = 16'h0100;
      repeat (10) @(negedge clk);
      check({status[0].start, status[0].trip}, 2'b10);
      repeat (8) @(negedge clk);
      check(status[0].start, 0);
      set0(3, 2, 0, 1, 0);
      wait_start(16'h0200);
      ratio = 16'h0100;
      repeat (10) @(negedge clk);
      check(status[0].start, 0);
      quiet;
   endtask
   // pick for hi ticks, drop for lo ticks, maybe repick, trip checked at tick chk
   task run_t(input int hi, lo, chk, input logic repick, exp);
      wait_start(16'h0200);
      repeat (hi * 8) @(negedge clk);
      ratio = 16'h0100;
      repeat (lo * 8) @(negedge clk);
      if (repick) ratio = 16'h0200;
      repeat ((chk - hi - lo) * 8 + 4) @(negedge clk);
      check(status[0].trip, exp);
      quiet;
   endtask
   task t_release;
      set0(4, 3, 1, 1, 0);
      run_t(1, 1, 5, 1, 1);
      set0(4, 3, 1, 0, 0);
      run_t(1, 1, 5, 1, 0);
      set0(4, 3, 1, 1, 1);
      run_t(1, 1, 4, 1, 1);
      set0(2, 6, 1, 1, 1);
      run_t(0, 0, 3, 0, 0);
   endtask
   task t_block;
      set0(2, 0, 1, 1, 0);
      blk_req = 1;
      ratio = 16'h0200;
      repeat (24) @(negedge clk);
      check({status[0].start, status[0].blocked}, 2'b01);
      quiet;
   endtask
   // inverse mode, k of 0.01 s gives a threshold of 512 in the accumulator
   task t_inverse;
      for (int u = 0; u < 2; u++) begin
         set0(2, 2, 1, 1, 0);
         cfg[0].inverse = 1;
         cfg[0].under = u[0];
         cfg[0].k_dial = 13'h0001;
         under = u[0];
         check(pow_exp[0], `SVT_DEF_EXPONENT);
         wait_start(u ? 16'h0080 : 16'h0200);
         repeat (u * 16 + 4) @(negedge clk);
         check(status[0].trip, 0);
         repeat (8) @(negedge clk);
         check(status[0].trip, 1);
         quiet;
      end
      under = 0;
   endtask
   task t_events;
      int base;
      volt = 16'h2345;
      count_clear = 1;
      event_sel = {3{2'b01}};
      @(negedge clk);
      count_clear = 0;
      repeat (2) @(negedge clk);
      check(ev_cnt[2][0], 0);
      base = ev_seen;
      pk[2] = 1;
      // start and trip rise together; start leaves the stream first
      for (int i = 0; i < 40 && ev_valid !== 1'b1; i++) @(negedge clk);
      check({ev_valid, ev_msg.rising}, 2'b11);
      check({ev_msg.stage, ev_msg.kind}, {2'h2, SVT_EV_START});
      @(negedge clk);
      check({ev_valid, ev_msg.rising}, 2'b11);
      check({ev_msg.stage, ev_msg.kind}, {2'h2, SVT_EV_TRIP});
      repeat (40) @(negedge clk);
      check({ev_cnt[2][0], ev_cnt[2][1], ev_cnt[1][0]}, 48'h000100010000);
      check(ev_seen - base, 2);
      log_stage = 2;
      repeat (2) @(negedge clk);
      check({log_valid, log_data.kind, log_data.group}, {1'b1, SVT_EV_TRIP, 3'h5});
      check(log_data.v_fault, 16'h2345);
      check({log_data.v_pre20, log_data.v_pre200}, 32'h12341234);
      log_age = 2;
      repeat (2) @(negedge clk);
      check(log_valid, 0);
      event_sel = {3{2'b11}};
      pk[2] = 0;
      repeat (40) @(negedge clk);
      check(ev_seen - base, 4);
      count_clear = 1;
      repeat (2) @(negedge clk);
      check(ev_cnt[2][1], 0);
      count_clear = 0;
   endtask
   initial begin
      for (int s = 0; s < 4; s++) begin
         cfg[s] = '0;
         cfg[s].exponent = `SVT_DEF_EXPONENT;
      end
      repeat (12) @(negedge clk);
      rst = 0;
      t_instant;
      t_definite;
      t_release;
      t_block;
      t_inverse;
      t_events;
      final_report;
   end
   // hang guard, well beyond the roughly 1400 cycles the scenarios need
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      final_report;
   end
endmodule
